/* File: logic/dcc_defines.svh */
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
// register indices; the byte address is four times the index
`define DCC_IDX_INTCTL   8'h0b
`define DCC_IDX_PFLAGS   8'h0c
`define DCC_IDX_CMPCTL   8'h1f
`define DCC_IDX_PADATA   8'h05
`define DCC_IDX_PADIR    8'h85
`define DCC_IDX_PENA     8'h8c
`define DCC_IDX_REFCTL   8'h9f
`define DCC_IDX_STATUS   8'ha0
`define DCC_IDX_SYSCTL   8'ha1
// reset values
`define DCC_RST_CMPCTL   8'h00
`define DCC_RST_PADIR    8'h3f
`define DCC_RST_ZERO     8'h00
// field positions
`define DCC_BIT_CHG      6
`define DCC_BIT_PERIPH_EN 6
`define DCC_BIT_GLOBAL_EN 7
`define DCC_BIT_SWITCH   3
// mode codes
`define DCC_MODE_RESET   3'b000
`define DCC_MODE_INTREF  3'b010
`define DCC_MODE_PINOUT  3'b110
`define DCC_MODE_OFF     3'b111
// pin positions on port a
`define DCC_PIN_FIRST    3
`define DCC_PIN_SECOND   4
`endif

/* File: logic/dcc_pkg.sv */
package dcc_pkg;
  typedef logic [2:0] dcc_mode_t;
  // apb request carried as one struct
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } dcc_apb_req_s;
  // analog-side controls
  typedef struct packed {
    logic      powered;
    logic      ref_to_plus;
    logic      input_switch;
    dcc_mode_t mode;
  } dcc_analog_ctl_s;
endpackage

/* File: logic/dcc_sync2.sv */
`timescale 1ns/100ps
// two-flop synchroniser for the raw comparator results
module dcc_sync2 #(
  parameter int WIDTH = 2
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // first stage only feeds second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

/* File: logic/dcc_top.sv */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "dcc_defines.svh"
// Functional notes
// [R1] result high when plus input exceeds minus
// [R2] mode 010 routes internal reference plus
// [R3] results read at bits 7:6, write-protected
// [R4] mode 110 routes raw results to pins
// [R5] direction bits still enable routed outputs
// [R6] analog pins read zero on port data
// [R7] any result change sets change flag
// [R8] flag at bit 6, software clears
// [R9] interrupt needs three enables set
// [R10] control access ends mismatch condition
// [R11] persisting mismatch keeps setting flag
// [R12] software tracks previous result bits
// [R13] sleep keeps comparators, interrupt wakes
// [R14] mode 111 powers comparators off
// [R15] wake leaves control register unchanged
// [R16] reset returns control to mode 000
// [R17] comparators powered down during reset
// [R18] three-bit field selects eight modes
// [R19] software disables interrupt during mode change
// [R20] synchronise results, compare with latched copy
// [R21] mode bits 2:0, switch bit 3, 5:4 zero
module dcc_top (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [1:0]                  cmp_raw,
  input  wire logic [5:0]                  port_a_in,
  output logic      [5:0]                  port_a_out,
  output logic      [5:0]                  port_a_oe,
  output dcc_pkg::dcc_analog_ctl_s         analog_ctl,
  output logic      [7:0]                  reference_ctl,
  output logic                             cpu_irq,
  output logic                             wake_req
);
  dcc_pkg::dcc_apb_req_s req;
  logic [7:0]            comparator_control_reg;
  logic [7:0]            interrupt_control_reg;
  logic [7:0]            peripheral_flags_reg;
  logic [7:0]            peripheral_enables_reg;
  logic [7:0]            port_a_direction_reg;
  logic [7:0]            port_a_data_reg;
  logic [7:0]            reference_control_reg;
  logic                  sleep_reg;
  logic [1:0]            result_sync;
  logic [1:0]            latched_reg;
  logic                  mismatch;
  logic                  wr_stb;
  logic                  rd_stb;
  logic                  cmp_access;
  logic [7:0]            wbyte;
  logic [5:0]            analog_pins;
  logic [31:0]           rdata_next;
  logic                  err_next;
  logic [1:0]            pin_val;
  logic                  irq_next;
  logic                  setup_phase;
  logic                  access_phase;
  logic                  wr_intctl;
  logic                  wr_pflags;
  logic                  wr_cmpctl;
  logic                  wr_padir;
  logic                  wr_padata;
  logic                  wr_pena;
  logic                  wr_refctl;
  logic                  wr_sysctl;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

  // word address decode: printed index times four
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'b00) && (a[11:2] == {2'b00, idx});
  endfunction

  // pins that the current mode leaves analog
  function automatic logic [5:0] analog_map(input dcc_pkg::dcc_mode_t m);
    unique case (m)
      3'b000:  analog_map = 6'h0f;
      3'b001:  analog_map = 6'h0f;
      3'b010:  analog_map = 6'h0f;
      3'b011:  analog_map = 6'h07;
      3'b100:  analog_map = 6'h03;
      3'b101:  analog_map = 6'h06;
      3'b110:  analog_map = 6'h07;
      3'b111:  analog_map = 6'h00;
    endcase
  endfunction

  // comparators run in every mode but reset and off
  function automatic logic mode_powered(input dcc_pkg::dcc_mode_t m);
    mode_powered = (m != `DCC_MODE_OFF) && (m != `DCC_MODE_RESET);
  endfunction

  // bus phases: setup answers, access commits
  assign setup_phase  = req.sel && !req.enable;
  assign access_phase = req.sel && req.enable;

  // single-cycle access phase strobes
  assign wr_stb      = access_phase && req.write;
  assign rd_stb      = access_phase && !req.write;
  assign wbyte       = req.wdata[7:0];
  assign cmp_access  = (wr_stb || rd_stb) && hit(req.addr, `DCC_IDX_CMPCTL); // R10
  assign analog_pins = analog_map(comparator_control_reg[2:0]); // R18 R6

  // per-register write enables
  assign wr_intctl = wr_stb && hit(req.addr, `DCC_IDX_INTCTL);
  assign wr_pflags = wr_stb && hit(req.addr, `DCC_IDX_PFLAGS);
  assign wr_cmpctl = wr_stb && hit(req.addr, `DCC_IDX_CMPCTL);
  assign wr_padir  = wr_stb && hit(req.addr, `DCC_IDX_PADIR);
  assign wr_padata = wr_stb && hit(req.addr, `DCC_IDX_PADATA);
  assign wr_pena   = wr_stb && hit(req.addr, `DCC_IDX_PENA);
  assign wr_refctl = wr_stb && hit(req.addr, `DCC_IDX_REFCTL);
  assign wr_sysctl = wr_stb && hit(req.addr, `DCC_IDX_SYSCTL);

  // synchronise raw results before detection
  dcc_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (cmp_raw),
    .sync_out (result_sync)
  );

  assign mismatch = (result_sync != latched_reg); // R20

  // comparator control: mode, switch bit, live results
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_control_reg <= `DCC_RST_CMPCTL; // R16
    end else begin
      comparator_control_reg[7:6] <= result_sync; // R3 R1
      comparator_control_reg[5:4] <= 2'b00; // R21
      if (wr_cmpctl) begin
        comparator_control_reg[3:0] <= wbyte[3:0]; // R21 R18
      end
    end
  end

  // latched copy refreshed on every control access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_reg <= 2'b00;
    end else if (cmp_access) begin
      latched_reg <= result_sync; // R10
    end
  end

  // change flag: set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_flags_reg <= `DCC_RST_ZERO;
    end else begin
      if (wr_pflags) begin
        peripheral_flags_reg <= wbyte; // R8
      end
      if (mismatch) begin
        peripheral_flags_reg[`DCC_BIT_CHG] <= 1'b1; // R7 R11
      end
    end
  end

  // interrupt control: global and peripheral enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_control_reg <= `DCC_RST_ZERO;
    end else if (wr_intctl) begin
      interrupt_control_reg <= wbyte; // R9
    end
  end

  // per-source interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_enables_reg <= `DCC_RST_ZERO;
    end else if (wr_pena) begin
      peripheral_enables_reg <= wbyte; // R9
    end
  end

  // port direction, bits 7:6 unimplemented
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_direction_reg <= `DCC_RST_PADIR;
    end else if (wr_padir) begin
      port_a_direction_reg <= {2'b00, wbyte[5:0]}; // R5
    end
  end

  // port output latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_data_reg <= `DCC_RST_ZERO;
    end else if (wr_padata) begin
      port_a_data_reg <= {2'b00, wbyte[5:0]};
    end
  end

  // reference ladder settings, bit 4 unimplemented
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_control_reg <= `DCC_RST_ZERO;
    end else if (wr_refctl) begin
      reference_control_reg <= {wbyte[7:5], 1'b0, wbyte[3:0]};
    end
  end

  // sleep request, cleared by the waking interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg <= 1'b0;
    end else if (wr_sysctl) begin
      sleep_reg <= wbyte[0];
    end else if (irq_next) begin
      sleep_reg <= 1'b0; // R13 R15
    end
  end

  // interrupt needs flag and three enables
  always_comb begin
    irq_next = peripheral_flags_reg[`DCC_BIT_CHG] && peripheral_enables_reg[`DCC_BIT_CHG]
               && interrupt_control_reg[`DCC_BIT_PERIPH_EN] && interrupt_control_reg[`DCC_BIT_GLOBAL_EN]; // R9
  end

  // interrupt request to the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq <= 1'b0;
    end else begin
      cpu_irq <= irq_next; // R9
    end
  end

  // wake request while sleeping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= sleep_reg && irq_next; // R13
    end
  end

  // analog controls: power, reference routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_ctl <= '0; // R17
    end else begin
      analog_ctl.mode         <= comparator_control_reg[2:0];
      analog_ctl.input_switch <= comparator_control_reg[`DCC_BIT_SWITCH];
      analog_ctl.powered      <= mode_powered(comparator_control_reg[2:0]); // R14 R17 R13
      analog_ctl.ref_to_plus  <= (comparator_control_reg[2:0] == `DCC_MODE_INTREF); // R2
    end
  end

  // reference ladder settings to the analog side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_ctl <= `DCC_RST_ZERO;
    end else begin
      reference_ctl <= reference_control_reg;
    end
  end

  // pin output mux; raw result in pin-output mode
  always_comb begin
    pin_val = {port_a_data_reg[`DCC_PIN_SECOND], port_a_data_reg[`DCC_PIN_FIRST]};
    if (comparator_control_reg[2:0] == `DCC_MODE_PINOUT) begin
      pin_val = cmp_raw; // R4
    end
  end

  // registered port data, results on pins 3 and 4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_out <= 6'h00;
    end else begin
      port_a_out <= port_a_data_reg[5:0];
      port_a_out[`DCC_PIN_FIRST]  <= pin_val[0]; // R4
      port_a_out[`DCC_PIN_SECOND] <= pin_val[1]; // R4
    end
  end

  // output enables, direction bit 1 = input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_oe <= 6'h00;
    end else begin
      port_a_oe <= ~port_a_direction_reg[5:0] & ~analog_pins; // R5
    end
  end

  // read mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    if (hit(req.addr, `DCC_IDX_CMPCTL)) begin
      rdata_next[7:0] = comparator_control_reg; // R3
    end else if (hit(req.addr, `DCC_IDX_INTCTL)) begin
      rdata_next[7:0] = interrupt_control_reg;
    end else if (hit(req.addr, `DCC_IDX_PFLAGS)) begin
      rdata_next[7:0] = peripheral_flags_reg;
    end else if (hit(req.addr, `DCC_IDX_PENA)) begin
      rdata_next[7:0] = peripheral_enables_reg;
    end else if (hit(req.addr, `DCC_IDX_PADIR)) begin
      rdata_next[7:0] = port_a_direction_reg;
    end else if (hit(req.addr, `DCC_IDX_PADATA)) begin
      rdata_next[7:0] = {2'b00, port_a_in & ~analog_pins}; // R6
    end else if (hit(req.addr, `DCC_IDX_REFCTL)) begin
      rdata_next[7:0] = reference_control_reg;
    end else if (hit(req.addr, `DCC_IDX_STATUS)) begin
      rdata_next[7:0] = {5'b00000, mismatch, latched_reg};
    end else if (hit(req.addr, `DCC_IDX_SYSCTL)) begin
      rdata_next[7:0] = {7'b0000000, sleep_reg};
    end else begin
      err_next = 1'b1;
    end
  end

  // apb handshake: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && err_next;
    end
  end

  // read data stands only with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (setup_phase && !req.write) ? rdata_next : 32'h0000_0000; // R3 R6
    end
  end
endmodule

/* File: test/dcc_top_sva.sv */
`timescale 1ns/100ps
// port-level checks of the comparator control block
module dcc_top_sva (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [11:0]              paddr,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic [1:0]               cmp_raw,
  input wire logic [5:0]               port_a_out,
  input wire dcc_pkg::dcc_analog_ctl_s analog_ctl,
  input wire logic                     cpu_irq
);
  // bus handshake
  property p_ready_first;
    @(posedge pclk) disable iff (!presetn) psel && !penable |=> pready;
  endproperty
  a_ready_first: assert property (p_ready_first) else $error("no answer in first access cycle");
  property p_ready_one;
    @(posedge pclk) disable iff (!presetn) pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready held too long");
  property p_rdata_zero;
    @(posedge pclk) disable iff (!presetn) !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside answer");
  property p_err_ready;
    @(posedge pclk) disable iff (!presetn) pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  // analog controls and result pins follow the mode field; reset state
  property p_power_mode;
    @(posedge pclk) disable iff (!presetn)
      analog_ctl.powered == !(analog_ctl.mode == 3'b000 || analog_ctl.mode == 3'b111);
  endproperty
  a_power_mode: assert property (p_power_mode) else $error("power state wrong for mode");
  property p_ref_plus;
    @(posedge pclk) disable iff (!presetn) analog_ctl.ref_to_plus == (analog_ctl.mode == 3'b010);
  endproperty
  a_ref_plus: assert property (p_ref_plus) else $error("reference routing wrong");
  property p_pin_route;
    @(posedge pclk) disable iff (!presetn)
      analog_ctl.mode == 3'b110 && $past(analog_ctl.mode) == 3'b110 |-> port_a_out[4:3] == $past(cmp_raw);
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pins do not carry results");
  property p_rst_mode;
    @(posedge pclk) disable iff (!presetn) $rose(presetn) |-> analog_ctl.mode == 3'b000;
  endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("mode not cleared by reset");
  property p_rst_off;
    @(posedge pclk) !presetn |-> !analog_ctl.powered && !cpu_irq;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("powered during reset");
  // main scenarios
  c_cmp_wr: cover property (@(posedge pclk) psel && penable && pready && pwrite && paddr == 12'h07c);
  c_irq: cover property (@(posedge pclk) $rose(cpu_irq));
  c_err: cover property (@(posedge pclk) pslverr);
endmodule
bind dcc_top dcc_top_sva dcc_top_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmp_raw(cmp_raw), .port_a_out(port_a_out), .analog_ctl(analog_ctl), .cpu_irq(cpu_irq));

/* File: test/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, err, cpu_irq, wake_req;
  logic [11:0]              paddr;
  logic [31:0]              pwdata, prdata, rd;
  logic [1:0]               cmp_raw;
  logic [5:0]               port_a_in, port_a_out, port_a_oe;
  logic [7:0]               reference_ctl;
  dcc_pkg::dcc_analog_ctl_s analog_ctl;
  int                       n_mismatch, n_checks, seed, n;
  localparam logic [11:0] A_INT = 12'h02c, A_FLG = 12'h030, A_CMP = 12'h07c, A_DAT = 12'h014;
  localparam logic [11:0] A_DIR = 12'h214, A_ENA = 12'h230, A_REF = 12'h27c, A_SYS = 12'h284;
  logic [11:0]              ra[6] = '{A_INT, A_FLG, A_CMP, A_DIR, A_ENA, A_REF};
  logic [31:0]              rv[6] = '{32'h0, 32'h0, 32'h0, 32'h3f, 32'h0, 32'h0};
  dcc_top dcc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw),
    .port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe), .analog_ctl(analog_ctl),
    .reference_ctl(reference_ctl), .cpu_irq(cpu_irq), .wake_req(wake_req));
  // expected control register read value
  function automatic logic [31:0] exp_cmp(logic [1:0] raw, logic [3:0] low);
    return {24'h0, raw[1], raw[0], 2'b00, low};
  endfunction
  task automatic stop_test;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  initial begin pclk = 1'b0; forever #4 pclk = ~pclk; end
  initial begin repeat (20000) @(posedge pclk); n_mismatch++; stop_test; end
  // main sequence
  initial begin
    seed = 90071; presetn <= 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; cmp_raw = 2'b00; port_a_in = 6'h3f;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk(analog_ctl, 6'h00);
    for (int i = 0; i < 6; i++) rdchk(ra[i], rv[i]);
    rdchk(12'h3fc, 32'h0); chk(err, 1'b1);
    apb(1'b1, A_CMP, 8'hff); rdchk(A_CMP, 32'h0f);
    cmp_raw <= 2'b01; repeat (4) @(posedge pclk);
    rdchk(A_CMP, exp_cmp(2'b01, 4'hf));
    for (int m = 0; m < 8; m++) begin
      cmp_raw <= 2'($random(seed));
      apb(1'b1, A_CMP, {4'h0, 1'b1, m[2:0]});
      repeat (3) @(posedge pclk);
      chk(analog_ctl, {exp_pow(m[2:0]), m[2:0] == 3'b010, 1'b1, m[2:0]});
    end
    cmp_raw <= 2'b00; apb(1'b1, A_CMP, 8'h03); repeat (4) @(posedge pclk);
    apb(1'b0, A_CMP, 8'h00); apb(1'b1, A_FLG, 8'h00); apb(1'b1, A_ENA, 8'h40); apb(1'b1, A_INT, 8'hc0);
    rdchk(A_FLG, 32'h00);
    cmp_raw <= 2'b10; repeat (6) @(posedge pclk);
    rdchk(A_FLG, 32'h40); chk(cpu_irq, 1'b1);
    apb(1'b1, A_FLG, 8'h00); rdchk(A_FLG, 32'h40);
    rdchk(A_CMP, exp_cmp(2'b10, 4'h3)); apb(1'b1, A_FLG, 8'h00); rdchk(A_FLG, 32'h00);
    repeat (4) @(posedge pclk); chk(cpu_irq, 1'b0);
    apb(1'b1, A_INT, 8'h40); cmp_raw <= 2'b11; repeat (6) @(posedge pclk);
    rdchk(A_FLG, 32'h40); chk(cpu_irq, 1'b0);
    apb(1'b0, A_CMP, 8'h00); apb(1'b1, A_FLG, 8'h00); apb(1'b1, A_INT, 8'hc0); apb(1'b1, A_SYS, 8'h01);
    cmp_raw <= 2'b01; n = 0;
    do begin @(posedge pclk); n++; end while (wake_req !== 1'b1 && n < 20);
    chk(n < 20, 1'b1); rdchk(A_CMP, exp_cmp(2'b01, 4'h3)); rdchk(A_SYS, 32'h0);
    apb(1'b1, A_INT, 8'h00);
    apb(1'b1, A_DIR, 8'h00); apb(1'b1, A_CMP, 8'h06);
    for (int i = 0; i < 6; i++) begin
      cmp_raw <= 2'($random(seed)); repeat (3) @(posedge pclk);
      chk(port_a_out[4:3], cmp_raw); chk(port_a_oe[4:3], 2'b11);
    end
    apb(1'b1, A_DIR, 8'h18); repeat (3) @(posedge pclk); chk(port_a_oe[4:3], 2'b00);
    apb(1'b1, A_CMP, 8'h00); repeat (3) @(posedge pclk); apb(1'b0, A_DAT, 8'h00); chk(rd & 32'h7, 32'h0);
    apb(1'b1, A_REF, 8'hff); repeat (2) @(posedge pclk); chk(reference_ctl, 8'hef); rdchk(A_REF, 32'hef);
    apb(1'b1, A_CMP, 8'h0b); presetn <= 1'b0; repeat (2) @(posedge pclk);
    chk(analog_ctl.powered, 1'b0); presetn <= 1'b1;
    apb(1'b0, A_CMP, 8'h00); chk(rd & 32'h3f, 32'h0);
    stop_test;
  end
  function automatic logic exp_pow(logic [2:0] m);
    return !(m == 3'b000 || m == 3'b111);
  endfunction
endmodule
